// >>> rtl/uds_defines.svh
// Constants for the USB device state control block.
// Assumes a 100 MHz system clock and classic Wishbone register access.
`ifndef UDS_DEFINES_SVH
`define UDS_DEFINES_SVH
`define UDS_CLK_MHZ 100
`define UDS_IDLE_MS 3
`define UDS_IDLE_CYC (`UDS_IDLE_MS * 1000 * `UDS_CLK_MHZ)
`define UDS_NUM_EP 7
`define UDS_RAM_BYTES 1024
// Register word byte addresses
`define UDS_A_CTRL 8'h00
`define UDS_A_STAT 8'h04
`define UDS_A_DEVCON 8'h08
`define UDS_A_DEVIRQ 8'h0c
`define UDS_A_EPRST 8'h10
`define UDS_A_EPCFG0 8'h20
`define UDS_A_EPSTA0 8'h40
`define UDS_A_EPCON0 8'h60
// Control register bits
`define UDS_C_EN 0
`define UDS_C_FRZ 1
`define UDS_C_PINEN 2
`define UDS_C_ROLE 3
`define UDS_C_LS 4
`define UDS_CTRL_RST 32'h0000_0006
// Status register bits
`define UDS_S_VBUS 0
`define UDS_S_ID 1
`define UDS_S_SUPPLY_CHANGE_FLAG 2
`define UDS_S_PLUG_ID_CHANGE_FLAG 3
`define UDS_S_PAD 4
`define UDS_S_IRQ 5
// Device control bits
`define UDS_D_ADDR_W 7
`define UDS_D_ADDR_APPLY 7
`define UDS_D_DETACH 8
// Device interrupt flags
`define UDS_I_SUSPEND_FLAG 0
`define UDS_I_WAKE 1
`define UDS_I_BUS_RESET_END_FLAG 2
// Endpoint config fields
`define UDS_F_MEMORY_CLAIM 0
`define UDS_F_BK 2
`define UDS_F_SIZE 4
`define UDS_F_DIR 8
`define UDS_F_TYPE 11
// Endpoint status / control bits
`define UDS_E_CONFIG_VALID 18
`define UDS_E_TOGGLE_SEQUENCE 8
`define UDS_E_TOGGLE_CLEAR_REQ 18
`endif

// >>> rtl/uds_device_ctrl.sv
// Device-side state control: pad suspend, supply and role detection,
// device states, endpoint enable/reset checks and address filtering.
// Assumes line events come from same-clock logic; pins are asynchronous.
`include "uds_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module uds_device_ctrl
#(
   parameter int IDLE_CYC = `UDS_IDLE_CYC
)
(
   input wire logic clk,
   input wire logic rst,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic session_ok,
   input wire logic supply_high_ok,
   input wire logic plug_id_pin,
   input wire uds_pkg::uds_line_s line_i,
   input wire logic [3:0] pkt_ep,
   input wire logic [6:0] pkt_addr,
   output logic pkt_accept,
   output uds_pkg::uds_pad_s pad_o,
   output logic usb_irq
);
   // Pin synchronisers
   logic [2:0] sync1_ff;
   logic [2:0] sync2_ff;
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         // Plug pin rests high; resetting it low would fake a role change
         sync1_ff <= 3'h4;
         sync2_ff <= 3'h4;
      end
      else
      begin
         sync1_ff <= {plug_id_pin, supply_high_ok, session_ok};
         sync2_ff <= sync1_ff;
      end
   end
   wire logic sess_s = sync2_ff[0];
   wire logic high_s = sync2_ff[1];
   wire logic pin_s = sync2_ff[2];

   logic [31:0] ctrl_ff;
   logic [8:0] devcon_ff;
   logic [2:0] dirq_ff;
   logic vbus_ff, supply_change_flag_ff, plug_id_change_flag_ff, id_prev_ff;
   logic [6:0] epen_ff, eprst_ff, toggle_clear_req_ff, toggle_sequence_ff;
   logic [15:0] epcfg_ff [`UDS_NUM_EP];
   logic [6:0] config_valid_ff;
   logic [7:0] epsta_irq_ff [`UDS_NUM_EP];
   logic [31:0] idle_cnt_ff;
   uds_pkg::uds_state_e state_ff;

   // Writes land at the edge that sees ack high, as the master expects
   wire logic wr = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;
   wire logic controller_enable = ctrl_ff[`UDS_C_EN];
   wire logic frz = ctrl_ff[`UDS_C_FRZ];
   // Role bit: 1 is device
   wire logic role_dev = ctrl_ff[`UDS_C_PINEN] ? pin_s :
      ctrl_ff[`UDS_C_ROLE];
   wire logic dev_on = controller_enable & role_dev;
   wire logic detach = devcon_ff[`UDS_D_DETACH];
   wire logic bus_rst = line_i.bus_reset & (state_ff == uds_pkg::UDS_ACTIVE);

   // Byte lane write merge
   function automatic logic [31:0] merge(input logic [31:0] old,
      input logic [31:0] d, input logic [3:0] sel);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++)
         if (sel[i])
            r[i*8 +: 8] = d[i*8 +: 8];
      return r;
   endfunction : merge

   // Size/bank legality: 8<<size bytes times banks within limits
   function automatic logic cfg_ok(input logic [15:0] c, input int ep);
      int bytes;
      bytes = (8 << c[`UDS_F_SIZE +: 3]) * (int'(c[`UDS_F_BK +: 2]) + 1);
      return (c[`UDS_F_BK +: 2] != 2'h3) &&
         (ep != 0 || c[`UDS_F_BK +: 2] == 2'h0) &&
         (bytes <= `UDS_RAM_BYTES);
   endfunction : cfg_ok

   // Control bits survive controller disable; reset only by rst
   always_ff @(posedge clk)
   begin
      if (rst)
         ctrl_ff <= `UDS_CTRL_RST;
      else if (wr && wb_adr_i == `UDS_A_CTRL)
         ctrl_ff <= merge(ctrl_ff, wb_dat_i, wb_sel_i) & 32'h0000_001f;
   end

   // Device state: reset, idle after enable, active on bus activity
   always_ff @(posedge clk)
   begin
      if (rst || !dev_on)
         state_ff <= uds_pkg::UDS_RESET;
      else
         case (state_ff)
            uds_pkg::UDS_RESET: state_ff <= uds_pkg::UDS_IDLE;
            uds_pkg::UDS_IDLE:
               if (line_i.bus_nonidle && !detach)
                  state_ff <= uds_pkg::UDS_ACTIVE;
            uds_pkg::UDS_ACTIVE:
               if (detach || dirq_ff[`UDS_I_SUSPEND_FLAG])
                  state_ff <= uds_pkg::UDS_IDLE;
            default: state_ff <= uds_pkg::UDS_RESET;
         endcase
   end

   // Idle bus timer for suspend detection
   always_ff @(posedge clk)
   begin
      if (rst || !dev_on || !line_i.bus_idle)
         idle_cnt_ff <= 32'h0;
      else if (idle_cnt_ff < IDLE_CYC)
         idle_cnt_ff <= idle_cnt_ff + 32'h1;
   end
   wire logic suspend_flag_ev = dev_on && line_i.bus_idle &&
      idle_cnt_ff == IDLE_CYC - 1;
   wire logic wake_ev = dev_on && line_i.bus_nonidle;

   // Device flags; write one clears, events win over clears
   always_ff @(posedge clk)
   begin
      if (rst || !dev_on)
         dirq_ff <= 3'h0;
      else
      begin
         if (wr && wb_adr_i == `UDS_A_DEVIRQ)
            dirq_ff <= dirq_ff & ~wb_dat_i[2:0];
         if (suspend_flag_ev)
         begin
            dirq_ff[`UDS_I_SUSPEND_FLAG] <= 1'b1;
            dirq_ff[`UDS_I_WAKE] <= 1'b0;
         end
         if (wake_ev)
         begin
            dirq_ff[`UDS_I_WAKE] <= 1'b1;
            dirq_ff[`UDS_I_SUSPEND_FLAG] <= 1'b0;
         end
         if (line_i.bus_reset && !dirq_ff[`UDS_I_BUS_RESET_END_FLAG] && state_ff ==
            uds_pkg::UDS_ACTIVE)
            dirq_ff[`UDS_I_BUS_RESET_END_FLAG] <= 1'b0;
      end
   end

   // End of bus reset detected by falling edge of the reset indication
   logic busrst_d_ff;
   always_ff @(posedge clk)
   begin
      if (rst)
         busrst_d_ff <= 1'b0;
      else
         busrst_d_ff <= bus_rst;
   end
   logic bus_reset_end_flag_ff;
   always_ff @(posedge clk)
   begin
      if (rst || !dev_on)
         bus_reset_end_flag_ff <= 1'b0;
      else if (busrst_d_ff && !bus_rst)
         bus_reset_end_flag_ff <= 1'b1;
      else if (wr && wb_adr_i == `UDS_A_DEVIRQ && wb_dat_i[`UDS_I_BUS_RESET_END_FLAG])
         bus_reset_end_flag_ff <= 1'b0;
   end

   // Address and detach; address cleared on rst, controller disable and bus reset
   always_ff @(posedge clk)
   begin
      if (rst)
         devcon_ff <= 9'h100;
      else if (!controller_enable || bus_rst)
         devcon_ff <= {devcon_ff[`UDS_D_DETACH], 8'h00};
      else if (wr && wb_adr_i == `UDS_A_DEVCON)
         devcon_ff <= wb_dat_i[8:0];
   end

   // Supply presence with role-dependent hysteresis
   always_ff @(posedge clk)
   begin
      if (rst)
         vbus_ff <= 1'b0;
      else if (role_dev)
         vbus_ff <= sess_s;
      else if (high_s)
         vbus_ff <= 1'b1;
      else if (!sess_s)
         vbus_ff <= 1'b0;
   end
   logic vbus_prev_ff;
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         vbus_prev_ff <= 1'b0;
         id_prev_ff <= 1'b1;
      end
      else
      begin
         vbus_prev_ff <= vbus_ff;
         id_prev_ff <= role_dev;
      end
   end
   // Transition flags work even with the controller disabled
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         supply_change_flag_ff <= 1'b0;
         plug_id_change_flag_ff <= 1'b0;
      end
      else
      begin
         if (vbus_prev_ff != vbus_ff)
            supply_change_flag_ff <= 1'b1;
         else if (wr && wb_adr_i == `UDS_A_STAT && wb_dat_i[`UDS_S_SUPPLY_CHANGE_FLAG])
            supply_change_flag_ff <= 1'b0;
         if (id_prev_ff != role_dev)
            plug_id_change_flag_ff <= 1'b1;
         else if (wr && wb_adr_i == `UDS_A_STAT && wb_dat_i[`UDS_S_PLUG_ID_CHANGE_FLAG])
            plug_id_change_flag_ff <= 1'b0;
      end
   end

   // Endpoint enable and reset bits
   always_ff @(posedge clk)
   begin
      if (rst || !dev_on)
      begin
         epen_ff <= 7'h00;
         eprst_ff <= 7'h00;
      end
      else if (bus_rst)
         epen_ff <= epen_ff & 7'h01;
      else if (wr && wb_adr_i == `UDS_A_EPRST)
      begin
         epen_ff <= wb_dat_i[6:0];
         eprst_ff <= wb_dat_i[22:16];
      end
   end

   // Per-endpoint configuration, status sources, toggle and requests
   always_ff @(posedge clk)
   begin
      for (int n = 0; n < `UDS_NUM_EP; n++)
      begin
         if (rst || !dev_on)
         begin
            epcfg_ff[n] <= 16'h0000;
            config_valid_ff[n] <= 1'b0;
            epsta_irq_ff[n] <= 8'h00;
            toggle_sequence_ff[n] <= 1'b0;
            toggle_clear_req_ff[n] <= 1'b0;
         end
         else
         begin
            // Configuration survives endpoint reset and disable
            if (wr && wb_adr_i == 8'(`UDS_A_EPCFG0 + 4 * n))
            begin
               epcfg_ff[n] <= wb_dat_i[15:0];
               config_valid_ff[n] <= wb_dat_i[`UDS_F_MEMORY_CLAIM] &&
                  cfg_ok(wb_dat_i[15:0], n);
            end
            // Status sources kept across bus reset
            if (wr && wb_adr_i == 8'(`UDS_A_EPSTA0 + 4 * n))
               epsta_irq_ff[n] <= epsta_irq_ff[n] & ~wb_dat_i[7:0];
            if (!epen_ff[n] || toggle_clear_req_ff[n] || (n == 0 && bus_rst))
               toggle_sequence_ff[n] <= 1'b0;
            if (eprst_ff[n] || !epen_ff[n])
               toggle_clear_req_ff[n] <= 1'b0;
            else if (wr && wb_adr_i == 8'(`UDS_A_EPCON0 + 4 * n) &&
               wb_dat_i[`UDS_E_TOGGLE_CLEAR_REQ])
               toggle_clear_req_ff[n] <= 1'b1;
            else
               toggle_clear_req_ff[n] <= 1'b0;
         end
      end
   end

   // Packet acceptance: address filter and endpoint readiness
   wire logic [6:0] my_addr = devcon_ff[`UDS_D_ADDR_APPLY] ? devcon_ff[6:0] :
      7'h00;
   wire logic [2:0] epi = (pkt_ep < 4'd7) ? pkt_ep[2:0] : 3'd0;
   assign pkt_accept = (state_ff == uds_pkg::UDS_ACTIVE) && !frz &&
      pkt_addr == my_addr && pkt_ep < 4'd7 && epen_ff[epi] &&
      !eprst_ff[epi] && config_valid_ff[epi];

   // Pad controls
   wire logic pad_idle = (state_ff != uds_pkg::UDS_ACTIVE);
   always_comb
   begin
      pad_o.rx_on = !pad_idle;
      pad_o.pulldown_on = pad_idle;
      pad_o.dp_pullup = dev_on && !detach && vbus_ff &&
         !ctrl_ff[`UDS_C_LS];
      pad_o.dm_pullup = dev_on && !detach && vbus_ff &&
         ctrl_ff[`UDS_C_LS];
   end

   // Frozen clock lets only the asynchronous sources through
   assign usb_irq = supply_change_flag_ff | plug_id_change_flag_ff | dirq_ff[`UDS_I_WAKE] |
      (!frz & (dirq_ff[`UDS_I_SUSPEND_FLAG] | bus_reset_end_flag_ff));

   // Wishbone read mux and single-cycle ack
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0;
      end
      else
      begin
         wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
         wb_dat_o <= 32'h0;
         case (wb_adr_i)
            `UDS_A_CTRL: wb_dat_o <= ctrl_ff;
            `UDS_A_STAT: wb_dat_o <= {26'h0, usb_irq, !pad_idle, plug_id_change_flag_ff,
               supply_change_flag_ff, role_dev, vbus_ff};
            `UDS_A_DEVCON: wb_dat_o <= {23'h0, devcon_ff};
            `UDS_A_DEVIRQ: wb_dat_o <= {29'h0, bus_reset_end_flag_ff,
               dirq_ff[`UDS_I_WAKE], dirq_ff[`UDS_I_SUSPEND_FLAG]};
            `UDS_A_EPRST: wb_dat_o <= {9'h0, eprst_ff, 9'h0, epen_ff};
            default:
               for (int n = 0; n < `UDS_NUM_EP; n++)
               begin
                  if (wb_adr_i == 8'(`UDS_A_EPCFG0 + 4 * n))
                     wb_dat_o <= {16'h0, epcfg_ff[n]};
                  if (wb_adr_i == 8'(`UDS_A_EPSTA0 + 4 * n))
                     wb_dat_o <= {13'h0, config_valid_ff[n], 9'h0, toggle_sequence_ff[n],
                        epsta_irq_ff[n]};
                  if (wb_adr_i == 8'(`UDS_A_EPCON0 + 4 * n))
                     wb_dat_o <= {13'h0, toggle_clear_req_ff[n], 18'h0};
               end
         endcase
      end
   end

   a_suspend_flag_wake_excl: assert property (@(posedge clk) disable iff (rst)
      !(dirq_ff[`UDS_I_SUSPEND_FLAG] && dirq_ff[`UDS_I_WAKE]))
      else $error("suspend and wake both set");
   a_suspend_flag_after_idle: assert property (@(posedge clk) disable iff (rst)
      suspend_flag_ev |=> dirq_ff[`UDS_I_SUSPEND_FLAG])
      else $error("suspend not set");
   a_wake_sets: assert property (@(posedge clk) disable iff (rst)
      wake_ev |=> dirq_ff[`UDS_I_WAKE] && !dirq_ff[`UDS_I_SUSPEND_FLAG])
      else $error("wake not set");
   a_pad_idle_pd: assert property (@(posedge clk) disable iff (rst)
      pad_idle |-> pad_o.pulldown_on && !pad_o.rx_on)
      else $error("idle pad wrong");
   a_pullup_gate: assert property (@(posedge clk) disable iff (rst)
      (pad_o.dp_pullup || pad_o.dm_pullup) |-> !detach && vbus_ff)
      else $error("pull-up while detached");
   a_vbus_change: assert property (@(posedge clk) disable iff (rst)
      $changed(vbus_ff) |=> supply_change_flag_ff)
      else $error("supply change missed");
   a_role_change: assert property (@(posedge clk) disable iff (rst)
      $changed(role_dev) |=> plug_id_change_flag_ff)
      else $error("role change missed");
   a_disable_reset: assert property (@(posedge clk) disable iff (rst)
      !dev_on |=> state_ff == uds_pkg::UDS_RESET)
      else $error("device not reset");
   a_epen_toggle: assert property (@(posedge clk) disable iff (rst)
      !epen_ff[0] |=> !toggle_sequence_ff[0])
      else $error("toggle not cleared");
   c_suspend: cover property (@(posedge clk) suspend_flag_ev);
   c_wake: cover property (@(posedge clk) wake_ev ##1 pad_o.rx_on);
   c_bus_reset: cover property (@(posedge clk) busrst_d_ff && !bus_rst);
   c_accept: cover property (@(posedge clk) pkt_accept);
endmodule : uds_device_ctrl
`default_nettype wire

// >>> rtl/uds_pkg.sv
// Types for the USB device state control block.
// Assumes uds_defines.svh is available to the design.
package uds_pkg;
   typedef enum logic [1:0] {
      UDS_RESET = 2'b00,
      UDS_IDLE = 2'b01,
      UDS_ACTIVE = 2'b11
   } uds_state_e;
   // Bus-side line state levels from the line receiver
   typedef struct packed {
      logic bus_idle;
      logic bus_nonidle;
      logic bus_reset;
   } uds_line_s;
   // Pad controls toward the transceiver
   typedef struct packed {
      logic rx_on;
      logic pulldown_on;
      logic dp_pullup;
      logic dm_pullup;
   } uds_pad_s;
endpackage : uds_pkg

// >>> tb/testbench.sv
// Self-checking bench for the device state control block.
// Assumes the host model on the bus side and Wishbone register access.
`include "uds_defines.svh"
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) \
   begin \
      samples_checked++; \
      if ((g) !== (e)) \
      begin \
         n_fail++; \
         $display("Error %s exp %h got %h", nm, e, g); \
      end \
   end
module testbench;
   localparam int IDLE = 20;
   logic clk, rst, cyc, stb, we, id_pin, acc, irq, ack, sok, shok;
   logic [7:0] adr;
   logic [3:0] sel, pep;
   logic [6:0] padr;
   logic [31:0] wdat, rdat, q;
   logic [1:0] lcmd;
   logic [12:0] mv;
   logic [12:0] hmv [4] = '{13'h578, 13'h1130, 13'h578, 13'h577};
   logic hexp [4] = '{1'b0, 1'b1, 1'b1, 1'b0};
   logic [31:0] cfg [4] = '{32'h69, 32'h75, 32'h1, 32'h65};
   logic [31:0] cok [4] = '{32'h0, 32'h0, 32'h40000, 32'h40000};
   uds_pkg::uds_line_s line;
   uds_pkg::uds_pad_s pad;
   int n_fail, samples_checked, cycles;

   uds_device_ctrl #(.IDLE_CYC(IDLE)) u_dut (.clk(clk), .rst(rst),
      .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .session_ok(sok), .supply_high_ok(shok), .plug_id_pin(id_pin),
      .line_i(line), .pkt_ep(pep), .pkt_addr(padr), .pkt_accept(acc),
      .pad_o(pad), .usb_irq(irq));
   uds_host_model u_host (.clk(clk), .line_cmd(lcmd), .supply_mv(mv),
      .line_o(line), .session_ok(sok), .supply_high_ok(shok));

   // Clock and cycle ceiling; a hang counts as a mismatch
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk)
   begin
      cycles++;
      if (cycles > 5000)
      begin
         n_fail++;
         test_done();
      end
   end

   task automatic test_done();
      if (n_fail == 0 && samples_checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : test_done

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask : tick

   // One classic cycle; request held until the edge that samples ack high
   task automatic xfer(input logic [7:0] a, input logic w,
      input logic [31:0] d);
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      do
         @(posedge clk);
      while (ack !== 1'b1);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask : xfer

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      xfer(a, 1'b1, d);
   endtask : wr

   task automatic chk_rd(input logic [7:0] a, input logic [31:0] m,
      input logic [31:0] e, input string nm);
      xfer(a, 1'b0, 32'h0);
      `CHK(nm, e, q & m)
   endtask : chk_rd

   // Accept decision is combinational; give it a cycle to settle
   task automatic chk_acc(input logic [3:0] ep, input logic [6:0] a,
      input logic e);
      pep <= ep;
      padr <= a;
      tick(1);
      `CHK("accept", e, acc)
   endtask : chk_acc

   initial
   begin
      rst = 1'b1;
      {cyc, stb, we, adr, wdat, sel, pep, padr, lcmd, mv} = '0;
      id_pin = 1'b1;
      sel = 4'hf;
      tick(2);
      rst <= 1'b0;
      chk_rd(`UDS_A_CTRL, 32'hffffffff, 32'h6, "ctrl");
      chk_rd(`UDS_A_DEVCON, 32'hffffffff, 32'h100, "devcon");
      `CHK("pad", 4'h4, pad)
      chk_rd(8'hfc, 32'hffffffff, 32'h0, "unmapped");
      // Device role, controller off: supply bit at the 1400 mV edge
      mv <= 13'h578;
      tick(5);
      chk_rd(`UDS_A_STAT, 32'h5, 32'h5, "vbus on");
      wr(`UDS_A_STAT, 32'hc);
      mv <= 13'h577;
      tick(5);
      chk_rd(`UDS_A_STAT, 32'h5, 32'h4, "vbus off");
      // Software host role, then supply hysteresis
      wr(`UDS_A_CTRL, 32'h0);
      chk_rd(`UDS_A_STAT, 32'ha, 32'h8, "soft host");
      wr(`UDS_A_STAT, 32'hc);
      for (int i = 0; i < 4; i++)
      begin
         mv <= hmv[i];
         tick(5);
         chk_rd(`UDS_A_STAT, 32'h1, {31'h0, hexp[i]}, "hyst");
      end
      // Role from the plug pin
      wr(`UDS_A_CTRL, 32'h4);
      chk_rd(`UDS_A_STAT, 32'ha, 32'ha, "pin dev");
      wr(`UDS_A_STAT, 32'hc);
      id_pin <= 1'b0;
      tick(5);
      chk_rd(`UDS_A_STAT, 32'ha, 32'h8, "pin host");
      id_pin <= 1'b1;
      tick(5);
      // Enable in device role: idle pad, no pull-up while detached
      wr(`UDS_A_CTRL, 32'h5);
      mv <= 13'h1130;
      tick(5);
      `CHK("pad", 4'h4, pad)
      wr(`UDS_A_DEVCON, 32'h0);
      tick(1);
      `CHK("fs pull", 2'h2, pad[1:0])
      wr(`UDS_A_CTRL, 32'h15);
      tick(1);
      `CHK("ls pull", 2'h1, pad[1:0])
      wr(`UDS_A_CTRL, 32'h5);
      mv <= 13'h0;
      tick(5);
      `CHK("no vbus", 2'h0, pad[1:0])
      mv <= 13'h1130;
      tick(5);
      wr(`UDS_A_STAT, 32'hc);
      // Activity wakes the pad, idle bus suspends it
      lcmd <= 2'h1;
      tick(5);
      `CHK("pad act", 4'ha, pad)
      chk_rd(`UDS_A_DEVIRQ, 32'h3, 32'h2, "wake");
      lcmd <= 2'h0;
      tick(10);
      chk_rd(`UDS_A_DEVIRQ, 32'h1, 32'h0, "early");
      tick(IDLE);
      chk_rd(`UDS_A_DEVIRQ, 32'h3, 32'h1, "suspend_flag");
      `CHK("pad sus", 2'h1, pad[3:2])
      wr(`UDS_A_CTRL, 32'h7);
      tick(1);
      `CHK("irq frz", 1'b0, irq)
      lcmd <= 2'h1;
      tick(5);
      chk_rd(`UDS_A_DEVIRQ, 32'h3, 32'h2, "wake2");
      `CHK("irq wake", 1'b1, irq)
      wr(`UDS_A_CTRL, 32'h5);
      wr(`UDS_A_DEVIRQ, 32'h7);
      // Endpoint configuration checks
      wr(`UDS_A_EPRST, 32'h3);
      for (int i = 0; i < 4; i++)
      begin
         wr(`UDS_A_EPCFG0 + {5'h0, i[0], 2'h0}, cfg[i]);
         chk_rd(`UDS_A_EPSTA0 + {5'h0, i[0], 2'h0}, 32'h40000, cok[i],
            "config_valid");
         if (i == 2)
            chk_acc(4'h1, 7'h0, 1'b0);
      end
      chk_acc(4'h1, 7'h0, 1'b1);
      chk_acc(4'h2, 7'h0, 1'b0);
      // Address setup in two steps
      wr(`UDS_A_DEVCON, 32'h5);
      chk_acc(4'h0, 7'h5, 1'b0);
      chk_acc(4'h0, 7'h0, 1'b1);
      wr(`UDS_A_DEVCON, 32'h85);
      chk_acc(4'h0, 7'h5, 1'b1);
      chk_acc(4'h0, 7'h0, 1'b0);
      // Endpoint reset keeps configuration and enables
      wr(`UDS_A_EPRST, 32'h20003);
      chk_rd(`UDS_A_EPCFG0 + 8'h4, 32'h1fff, 32'h65, "ep cfg");
      chk_rd(`UDS_A_EPRST, 32'h7f, 32'h3, "ep en");
      wr(`UDS_A_EPRST, 32'h3);
      wr(`UDS_A_EPCON0 + 8'h4, 32'h40000);
      tick(2);
      chk_rd(`UDS_A_EPSTA0 + 8'h4, 32'h100, 32'h0, "toggle");
      // Bus reset while active
      lcmd <= 2'h2;
      tick(5);
      lcmd <= 2'h1;
      tick(3);
      chk_rd(`UDS_A_DEVIRQ, 32'h4, 32'h4, "bus_reset_end_flag");
      chk_rd(`UDS_A_DEVCON, 32'hff, 32'h0, "addr clr");
      chk_rd(`UDS_A_EPRST, 32'h7f, 32'h1, "ep dis");
      chk_rd(`UDS_A_EPSTA0, 32'h100, 32'h0, "ep0 tog");
      chk_acc(4'h1, 7'h0, 1'b0);
      // Detach and disable idle the pad
      wr(`UDS_A_DEVCON, 32'h100);
      tick(2);
      `CHK("detach", 1'b0, pad[3])
      wr(`UDS_A_DEVCON, 32'h85);
      tick(3);
      `CHK("attach", 1'b1, pad[3])
      wr(`UDS_A_CTRL, 32'h4);
      tick(2);
      `CHK("disable", 2'h1, pad[3:2])
      chk_rd(`UDS_A_DEVCON, 32'hff, 32'h0, "dis addr");
      test_done();
   end
endmodule : testbench
`default_nettype wire

// >>> tb/uds_host_model.sv
// Host-side model: drives the bus line state and the supply pad level.
// Assumes the bench picks the line state and the supply in millivolts.
`timescale 1ns/1ps
`default_nettype none
module uds_host_model
(
   input wire logic clk,
   input wire logic [1:0] line_cmd,
   input wire logic [12:0] supply_mv,
   output uds_pkg::uds_line_s line_o,
   output logic session_ok,
   output logic supply_high_ok
);
   // Supply comparators: 1400 mV and 4400 mV thresholds
   assign session_ok = supply_mv >= 13'h578;
   assign supply_high_ok = supply_mv >= 13'h1130;
   // Line state moves just after an edge, one state at a time
   always_ff @(posedge clk)
   begin
      line_o.bus_idle <= line_cmd == 2'h0;
      line_o.bus_nonidle <= line_cmd == 2'h1;
      line_o.bus_reset <= line_cmd == 2'h2;
   end
endmodule : uds_host_model
`default_nettype wire
